//--- dtc_pkg.sv
package dtc_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;  // mode register image
  localparam logic [7:0] OFS_CFG  = 8'h04;  // precharge and clock period
  localparam logic [7:0] OFS_STAT = 8'h08;  // live device state
  localparam logic [7:0] OFS_ERR  = 8'h0c;  // sticky spacing, clock-change and suspect-read errors, w1c

  // mode register field positions
  localparam int MR_AL_LSB   = 0;   // additive latency, 3 bits
  localparam int MR_WR_LSB   = 4;   // write recovery in cycles, 4 bits
  localparam int MR_GR_LSB   = 8;   // speed grade, 2 bits
  localparam int MR_DQS_BIT  = 10;  // 0: differential strobe
  localparam int MR_SLOW_BIT = 12;  // 1: slow active power-down exit

  // config register field positions
  localparam int CF_TRP_LSB = 0;   // precharge period in ps
  localparam int CF_TCK_LSB = 16;  // average clock period in ps

  // reset values
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST  = 32'h0bb8_3a98;  // 3000 ps, 15000 ps
  localparam logic [7:0]  TNRP_RST = 8'h05;          // matches CFG_RST

  // status register bit positions
  localparam int ST_ODT      = 0;
  localparam int ST_PD       = 1;
  localparam int ST_SREF     = 2;
  localparam int ST_APD      = 3;
  localparam int ST_FOK      = 4;
  localparam int ST_DQSD     = 5;
  localparam int ST_BUSY     = 6;
  localparam int ST_TNRP_LSB = 8;
  localparam int ST_TDAL_LSB = 16;

  // error register bit positions
  localparam int ERR_W      = 5;
  localparam int ER_ACT_PDX = 0;  // activate too soon after exit
  localparam int ER_RD_PDX  = 1;  // read too soon after active exit
  localparam int ER_ACT_DAL = 2;  // activate inside write-ap interval
  localparam int ER_FREQ    = 3;  // clock change outside allowed states
  localparam int ER_SUSPECT = 4;  // read of possibly corrupt data

  // speed grades
  localparam logic [1:0] GR_667  = 2'b00;
  localparam logic [1:0] GR_800  = 2'b01;
  localparam logic [1:0] GR_1066 = 2'b10;

  // timing in clock cycles (nCK); clock period in ns
  localparam int ODT_ON_NCK       = 2;
  localparam int ODT_OFF_HALF_NCK = 5;  // 2.5 cycles in half cycles
  localparam int ODT_OFF_NCK      = (ODT_OFF_HALF_NCK + 1) / 2;
  localparam int XP_NCK_STD       = 2;
  localparam int XP_NCK_1066      = 3;
  localparam int XARD_FAST_NCK    = 2;
  localparam int XARDS_667_NCK    = 8;
  localparam int XARDS_OTH_NCK    = 7;
  localparam int CLK_PERIOD_NS    = 100;

  // spacing counter slots
  localparam int CI_ON   = 0;
  localparam int CI_OFF  = 1;
  localparam int CI_XP   = 2;
  localparam int CI_XARD = 3;
  localparam int CI_DAL  = 4;
  localparam int N_CNT   = 5;

  // registered command codes
  typedef enum logic [2:0] {
    CMD_NOP  = 3'b000,
    CMD_ACT  = 3'b001,
    CMD_RD   = 3'b010,
    CMD_WR   = 3'b011,
    CMD_WRA  = 3'b100,
    CMD_PRE  = 3'b101,
    CMD_SREF = 3'b110,
    CMD_MRS  = 3'b111
  } dtc_cmd_e;

  // pins from the controller
  typedef struct packed {
    logic       cke;      // clock enable
    logic       odt;      // termination control
    logic       clk_chg;  // controller is changing clock rate
    logic       cap_err;  // write capture setup/hold violated
    logic [2:0] cmd;      // registered command code
  } dtc_pins_s;

  // whole state of the top module except the spacing counters
  typedef struct packed {
    dtc_pins_s        m1;        // first sync stage
    dtc_pins_s        s;         // second sync stage
    logic             cke_p;     // previous cke
    logic             odt_p;     // previous odt
    logic [31:0]      mode;
    logic [31:0]      cfg;
    logic [7:0]       tnrp;
    logic [15:0]      rem;
    logic             busy;
    logic             bank_open;
    logic             pd;
    logic             apd;
    logic             sref;
    logic             suspect;
    logic             on_pend;
    logic             off_pend;
    logic             odt_term;
    logic [ERR_W-1:0] err;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             dqs_diff;
    logic             freq_ok;
  } dtc_state_s;

endpackage

//--- dtc_dcnt.sv
`timescale 1ns/1ps
// loadable down-counter; zero means the spacing has elapsed
module dtc_dcnt #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // load side
  input  wire logic         load,
  input  wire logic [W-1:0] val,
  // status
  output logic              zero
);

  logic [W-1:0] cnt_q;  // whole state
  logic [W-1:0] cnt_d;

  // load wins; otherwise count real edges down to zero and stay
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign zero = (cnt_q == '0);

endmodule // dtc_dcnt

//--- dtc_top.sv
`timescale 1ns/1ps
// How it works
// (RULE1) mode bit 12 picks fast/slow exit
// (RULE2) termination starts two edges after odt high
// (RULE3) termination stops 2.5 cycles after odt low
// (RULE4) clock change only in self refresh/precharge pd
// (RULE5) nanosecond spacings rounded up to cycles
// (RULE6) write-ap interval is wr plus rounded trp
// (RULE7) activate two or three edges after exit
// (RULE8) all spacings count real clock edges
// (RULE9) mode bit 10 zero means differential strobe
// (RULE10) long write postamble is no error
// (RULE11) capture violation data rewritten before read
// (RULE12) slow exit read waits 8-al or 7-al
// (RULE13) spacings kept as loaded down-counters
module dtc_top #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // pins from the controller
  input  wire dtc_pkg::dtc_pins_s pins,
  // device outputs
  output logic                   odt_term,
  output logic                   dqs_diff,
  output logic                   freq_ok
);
  import dtc_pkg::*;

  // counter must hold the widest write-ap interval
  if (CNT_W < 8) begin : g_chk
    $error("dtc_top: CNT_W must be at least 8");
  end

  dtc_state_s s_q;  // registered state
  dtc_state_s n;    // next state

  // decoded fields and events
  logic [2:0]       al;          // additive latency
  logic [3:0]       wr;          // write recovery
  logic [1:0]       grade;       // speed grade
  logic             slow_exit;   // slow active pd exit selected
  logic [15:0]      trp_ps;      // precharge period
  logic [15:0]      tck_ps;      // average clock period
  logic [7:0]       tdal;        // write-ap to activate
  dtc_cmd_e         cmd;         // synchronised command
  logic             odt_rise;
  logic             odt_fall;
  logic             pd_entry;
  logic             pd_exit;
  logic             sref_exit;
  logic [CNT_W-1:0] xp_nck;
  logic [CNT_W-1:0] xard_nck;
  logic             setup;       // apb setup phase seen
  logic             access;      // apb access completes
  logic             mapped;      // address hits a register

  // spacing counters
  logic [N_CNT-1:0] load_v;
  logic [CNT_W-1:0] val_v [N_CNT];
  logic [N_CNT-1:0] zero_v;

  // does this offset name a register
  function automatic logic hit(input logic [7:0] a);
    return (a == OFS_MODE) || (a == OFS_CFG) ||
           (a == OFS_STAT) || (a == OFS_ERR);
  endfunction

  // field decode from the mode and config images
  assign al        = s_q.mode[MR_AL_LSB +: 3];
  assign wr        = s_q.mode[MR_WR_LSB +: 4];
  assign grade     = s_q.mode[MR_GR_LSB +: 2];
  assign slow_exit = s_q.mode[MR_SLOW_BIT];
  assign trp_ps    = s_q.cfg[CF_TRP_LSB +: 16];
  assign tck_ps    = s_q.cfg[CF_TCK_LSB +: 16];
  assign tdal      = 8'(wr) + s_q.tnrp;  // [RULE6]
  assign cmd       = dtc_cmd_e'(s_q.s.cmd);

  // edges on synchronised pins, one per real clock edge [RULE8]
  assign odt_rise  = s_q.s.odt & ~s_q.odt_p;
  assign odt_fall  = ~s_q.s.odt & s_q.odt_p;
  assign pd_entry  = ~s_q.s.cke & s_q.cke_p & ~s_q.pd & ~s_q.sref;
  assign pd_exit   = s_q.s.cke & ~s_q.cke_p & s_q.pd;
  assign sref_exit = s_q.s.cke & ~s_q.cke_p & s_q.sref;

  // exit-to-activate: 3 edges at the fastest grade, else 2 [RULE7]
  assign xp_nck = (grade == GR_1066) ? CNT_W'(XP_NCK_1066)
                                     : CNT_W'(XP_NCK_STD);

  // exit-to-read chosen by mode bit 12 [RULE1] [RULE12]
  always_comb begin
    xard_nck = CNT_W'(XARD_FAST_NCK);
    if (slow_exit) begin
      if (grade == GR_667) begin
        xard_nck = CNT_W'(XARDS_667_NCK) - CNT_W'(al);
      end else begin
        xard_nck = CNT_W'(XARDS_OTH_NCK) - CNT_W'(al);
      end
      // large al would wrap; never wait less than one edge
      if (CNT_W'(al) >= CNT_W'(XARDS_OTH_NCK)) begin
        xard_nck = CNT_W'(1);
      end
    end
  end

  // counter loads: count n-1 so the dependent edge is Tm+n [RULE13]
  always_comb begin
    load_v          = '0;
    load_v[CI_ON]   = odt_rise;                    // [RULE2]
    load_v[CI_OFF]  = odt_fall;                    // [RULE3]
    load_v[CI_XP]   = pd_exit;                     // [RULE7]
    load_v[CI_XARD] = pd_exit & s_q.apd;           // [RULE1]
    load_v[CI_DAL]  = (cmd == CMD_WRA);            // [RULE6]
    val_v[CI_ON]    = CNT_W'(ODT_ON_NCK - 2);   // output flop adds an edge
    val_v[CI_OFF]   = CNT_W'(ODT_OFF_NCK - 2);  // output flop adds an edge
    val_v[CI_XP]    = xp_nck - CNT_W'(1);
    val_v[CI_XARD]  = xard_nck - CNT_W'(1);
    val_v[CI_DAL]   = (tdal == 8'h00) ? '0 : CNT_W'(tdal - 8'h01);
  end

  // one counter per tracked spacing
  for (genvar i = 0; i < N_CNT; i++) begin : g_cnt
    dtc_dcnt #(
      .W (CNT_W)
    ) u_cnt (
      .mclk (mclk),
      .rst  (rst),
      .load (load_v[i]),
      .val  (val_v[i]),
      .zero (zero_v[i])
    );
  end

  // apb phases; zero wait states, answer one edge after setup
  assign setup  = psel & ~penable & ~s_q.pready;
  assign access = psel & penable & s_q.pready;
  assign mapped = hit(paddr);

  // next-state logic for the whole block
  always_comb begin
    n = s_q;
    // two-flop synchronisers, then edge history
    n.m1    = pins;
    n.s     = s_q.m1;
    n.cke_p = s_q.s.cke;
    n.odt_p = s_q.s.odt;

    // rounding trp up to cycles by repeated subtraction [RULE5]
    if (s_q.busy) begin
      if (s_q.rem == 16'h0000 || tck_ps == 16'h0000) begin
        n.busy = 1'b0;
      end else begin
        n.rem  = (s_q.rem > tck_ps) ? s_q.rem - tck_ps : 16'h0000;
        n.tnrp = (s_q.tnrp == 8'hff) ? s_q.tnrp : s_q.tnrp + 8'h01;
      end
    end

    // bank tracking for active versus precharge power-down
    unique case (cmd)
      CMD_ACT:  n.bank_open = 1'b1;
      CMD_PRE:  n.bank_open = 1'b0;
      CMD_WRA:  n.bank_open = 1'b0;
      CMD_NOP,
      CMD_RD,
      CMD_WR,
      CMD_SREF,
      CMD_MRS:  n.bank_open = s_q.bank_open;
    endcase

    // power-down and self refresh entry and exit
    if (pd_entry) begin
      if (cmd == CMD_SREF) begin
        n.sref = 1'b1;
      end else begin
        n.pd  = 1'b1;
        n.apd = s_q.bank_open;
      end
    end
    if (pd_exit) begin
      n.pd  = 1'b0;
      n.apd = 1'b0;
    end
    if (sref_exit) begin
      n.sref = 1'b0;
    end

    // termination: off first so a coinciding on wins
    if (odt_rise) begin
      n.on_pend = 1'b1;
    end
    if (odt_fall) begin
      n.off_pend = 1'b1;
    end
    if (s_q.off_pend && zero_v[CI_OFF] && !odt_fall) begin
      n.off_pend = 1'b0;
      n.odt_term = 1'b0;  // [RULE3]
    end
    if (s_q.on_pend && zero_v[CI_ON] && !odt_rise) begin
      n.on_pend  = 1'b0;
      n.odt_term = 1'b1;  // [RULE2]
    end

    // capture violation marks data untrusted until rewritten
    if (cmd == CMD_WR || cmd == CMD_WRA) begin
      n.suspect = 1'b0;  // [RULE11]
    end
    if (s_q.s.cap_err) begin
      n.suspect = 1'b1;  // set beats a same-edge rewrite
    end
    // postamble length is never timed, so a long one raises nothing
    // [RULE10]

    // apb read data and error prepared in setup
    n.pready  = setup;
    n.pslverr = setup & ~mapped;
    n.prdata  = '0;
    if (setup && mapped && !pwrite) begin
      unique case (paddr)
        OFS_MODE: n.prdata = s_q.mode;
        OFS_CFG:  n.prdata = s_q.cfg;
        OFS_STAT: begin
          n.prdata[ST_ODT]               = s_q.odt_term;
          n.prdata[ST_PD]                = s_q.pd;
          n.prdata[ST_SREF]              = s_q.sref;
          n.prdata[ST_APD]               = s_q.apd;
          n.prdata[ST_FOK]               = s_q.freq_ok;
          n.prdata[ST_DQSD]              = s_q.dqs_diff;
          n.prdata[ST_BUSY]              = s_q.busy;
          n.prdata[ST_TNRP_LSB +: 8]     = s_q.tnrp;
          n.prdata[ST_TDAL_LSB +: 8]     = tdal;
        end
        default:  n.prdata[ERR_W-1:0]    = s_q.err;
      endcase
    end

    // apb writes take effect on the completing edge
    if (access && pwrite && mapped) begin
      unique case (paddr)
        OFS_MODE: n.mode = pwdata;
        OFS_CFG: begin
          n.cfg  = pwdata;
          n.rem  = pwdata[CF_TRP_LSB +: 16];
          n.tnrp = 8'h00;
          n.busy = 1'b1;
        end
        OFS_ERR:  n.err  = s_q.err & ~pwdata[ERR_W-1:0];
        default:  n.mode = s_q.mode;  // status is read-only
      endcase
    end

    // spacing, clock-change and suspect-read errors; a new event beats a same-edge clear
    if (cmd == CMD_ACT && !zero_v[CI_XP]) begin
      n.err[ER_ACT_PDX] = 1'b1;  // [RULE7]
    end
    if (cmd == CMD_RD && !zero_v[CI_XARD]) begin
      n.err[ER_RD_PDX] = 1'b1;  // [RULE1]
    end
    if (cmd == CMD_ACT && !zero_v[CI_DAL]) begin
      n.err[ER_ACT_DAL] = 1'b1;  // [RULE5]
    end
    if (s_q.s.clk_chg && !s_q.freq_ok) begin
      n.err[ER_FREQ] = 1'b1;  // [RULE4]
    end
    if (cmd == CMD_RD && s_q.suspect) begin
      n.err[ER_SUSPECT] = 1'b1;  // [RULE11]
    end

    // derived outputs follow the next state
    n.freq_ok  = n.sref | (n.pd & ~n.apd);  // [RULE4]
    n.dqs_diff = ~n.mode[MR_DQS_BIT];       // [RULE9]
  end

  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q      <= '0;
      s_q.mode <= MODE_RST;
      s_q.cfg  <= CFG_RST;
      s_q.tnrp <= TNRP_RST;
      s_q.dqs_diff <= ~MODE_RST[MR_DQS_BIT];
    end else begin
      s_q <= n;
    end
  end

  // outputs straight from flops
  assign prdata   = s_q.prdata;
  assign pready   = s_q.pready;
  assign pslverr  = s_q.pslverr;
  assign odt_term = s_q.odt_term;
  assign dqs_diff = s_q.dqs_diff;
  assign freq_ok  = s_q.freq_ok;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_ODT_ON: assert property ( // [RULE2]
    odt_rise |-> ##2 odt_term)
    else $error("termination not on two edges after odt high");

  AST_ODT_OFF: assert property ( // [RULE3]
    odt_fall ##1 !s_q.s.odt [*2] |=> !odt_term)
    else $error("termination not off after odt low");

  AST_PDX_ACT: assert property ( // [RULE7]
    (pd_exit && grade != GR_1066) ##1 (cmd == CMD_ACT)
      |=> s_q.err[ER_ACT_PDX])
    else $error("early activate after exit not flagged");

  AST_PDX_ACT_OK: assert property ( // [RULE8]
    (pd_exit && grade == GR_667 && !s_q.err[ER_ACT_PDX])
      ##2 (cmd == CMD_ACT && !access) |=> !s_q.err[ER_ACT_PDX])
    else $error("activate at exit spacing wrongly flagged");

  AST_XARD_SLOW: assert property ( // [RULE1]
    (pd_exit && s_q.apd && slow_exit && grade == GR_667 && al == 3'h0)
      ##7 (cmd == CMD_RD) |=> s_q.err[ER_RD_PDX])
    else $error("early read after slow exit not flagged");

  AST_XARD_FAST: assert property ( // [RULE1]
    (pd_exit && s_q.apd && !slow_exit) ##1 (cmd == CMD_RD)
      |=> s_q.err[ER_RD_PDX])
    else $error("early read after fast exit not flagged");

  AST_DAL: assert property ( // [RULE5]
    (cmd == CMD_WRA && tdal >= 8'h03) ##1 (cmd == CMD_ACT)
      |=> s_q.err[ER_ACT_DAL])
    else $error("activate inside write-ap interval not flagged");

  AST_FREQ: assert property ( // [RULE4]
    (s_q.s.clk_chg && !freq_ok) |=> s_q.err[ER_FREQ])
    else $error("clock change outside allowed state not flagged");

  AST_SUSPECT: assert property ( // [RULE11]
    (s_q.s.cap_err ##1 (cmd == CMD_RD)) |=> s_q.err[ER_SUSPECT])
    else $error("read of suspect data not flagged");

  AST_DQS: assert property ( // [RULE9]
    (access && pwrite && paddr == OFS_MODE)
      |=> dqs_diff == !$past(pwdata[MR_DQS_BIT]))
    else $error("strobe mode does not follow mode bit");

  AST_APB: assert property (
    (psel && !penable && !pready) |=> pready && (pslverr == !$past(mapped)))
    else $error("apb answer not one cycle after setup");

  COV_ODT: cover property (odt_rise ##[1:8] odt_term);
  COV_SLOW: cover property (pd_exit && s_q.apd && slow_exit);
  COV_FREQ: cover property (s_q.s.clk_chg && freq_ok);
  COV_TNRP: cover property ($fell(s_q.busy));

endmodule // dtc_top

//--- dtc_ctl_model.sv
`timescale 1ns/1ps
// controller stand-in: drives the pin bundle and keeps the exit and
// write-ap spacings unless the bench asks it to break them
module dtc_ctl_model (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // bench requests
  input  wire logic          req,
  input  wire logic [2:0]    req_cmd,
  input  wire logic          early,
  input  wire logic          cke_i,
  input  wire logic          odt_i,
  input  wire logic          chg_i,
  input  wire logic          cap_i,
  // programmed timing
  input  wire logic          slow,
  input  wire logic [2:0]    al,
  input  wire logic [1:0]    grade,
  input  wire logic [7:0]    tdal,
  // pins and status
  output dtc_pkg::dtc_pins_s pins,
  output logic               idle
);
  import dtc_pkg::*;
  logic [7:0] xp_q, rd_q, dal_q;  // edges left before act or read
  logic [7:0] xp_n, rd_n;         // spacing for current mode
  logic       pend_q;             // request waiting
  logic       early_q;            // skip spacing on purpose
  logic       go;                 // launch this edge
  logic [2:0] cmd_q;              // waiting command
  // spacings count real edges, never nanoseconds
  always_comb begin
    xp_n = (grade == GR_1066) ? 8'(XP_NCK_1066) : 8'(XP_NCK_STD);
    if (!slow) begin
      rd_n = 8'(XARD_FAST_NCK);
    end else begin
      rd_n = (grade == GR_667) ? 8'(XARDS_667_NCK) : 8'(XARDS_OTH_NCK);
      rd_n = rd_n - 8'(al);
    end
    if (rd_n == 8'h00) rd_n = 8'h01;
    // dependent command only once its counter is empty
    go = pend_q && (early_q || ((cmd_q != CMD_ACT ||
         (xp_q == 8'h00 && dal_q == 8'h00)) &&
         (cmd_q != CMD_RD || rd_q == 8'h00)));
  end
  assign idle = !pend_q;
  // one request in flight; each command stands one cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pins    <= '0;
      pins.cke <= 1'b1;
      xp_q    <= 8'h00;
      rd_q    <= 8'h00;
      dal_q   <= 8'h00;
      pend_q  <= 1'b0;
      early_q <= 1'b0;
      cmd_q   <= 3'h0;
    end else begin
      pins.cke     <= cke_i;
      pins.odt     <= odt_i;
      pins.clk_chg <= chg_i;  // bench changes rate only in pd or self refresh
      pins.cap_err <= cap_i;  // bench reads once without rewriting, then rewrites before reading
      pins.cmd     <= go ? cmd_q : CMD_NOP;
      xp_q  <= (xp_q != 8'h00) ? xp_q - 8'h01 : 8'h00;
      rd_q  <= (rd_q != 8'h00) ? rd_q - 8'h01 : 8'h00;
      dal_q <= (dal_q != 8'h00) ? dal_q - 8'h01 : 8'h00;
      if (cke_i && !pins.cke) begin
        xp_q <= xp_n - 8'h01;
        rd_q <= rd_n - 8'h01;
      end
      if (go && cmd_q == CMD_WRA) dal_q <= tdal - 8'h01;
      if (go) pend_q <= 1'b0;
      if (req) begin
        pend_q  <= 1'b1;
        cmd_q   <= req_cmd;
        early_q <= early;
      end
    end
  end
endmodule  // dtc_ctl_model

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dtc_pkg::*;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, lerr;
  logic        odt_term, dqs_diff, freq_ok, req, early, cke_i, odt_i;
  logic        chg_i, cap_i, slow, idle;
  logic [7:0]  paddr, tdal, nrp;
  logic [31:0] pwdata, prdata, r;
  logic [2:0]  rcmd, al;
  logic [1:0]  grade;
  logic [15:0] trp, tck;
  dtc_pins_s   pins;
  int          fail_count, checked, seed, i;
  // 10 MHz clock
  always #50 mclk = ~mclk;
  dtc_top i_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins),
    .odt_term(odt_term), .dqs_diff(dqs_diff), .freq_ok(freq_ok));
  dtc_ctl_model i_ctl (.mclk(mclk), .rst(rst), .req(req), .req_cmd(rcmd),
    .early(early), .cke_i(cke_i), .odt_i(odt_i), .chg_i(chg_i),
    .cap_i(cap_i), .slow(slow), .al(al), .grade(grade), .tdal(tdal),
    .pins(pins), .idle(idle));
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t saw %h expected %h", $time, s, e);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // apb transfer: hold until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    // no wait count assumed; the watchdog ends a hang
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    lerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // command through the model, cke set at the same edge
  task issue(input logic [2:0] c, input logic e, input logic ck);
    @(posedge mclk);
    {req, rcmd, early, cke_i} <= {1'b1, c, e, ck};
    @(posedge mclk);
    req <= 1'b0;
    @(posedge mclk);
    while (idle !== 1'b1) @(posedge mclk);
  endtask
  task pd_enter;
    @(posedge mclk);
    cke_i <= 1'b0;
    tick(8);
  endtask
  // read the sticky errors, then clear them
  task errchk(input logic [4:0] e);
    tick(6);
    apb(0, OFS_ERR, 0);
    chk(r[4:0], e);
    apb(1, OFS_ERR, 32'h1f);
  endtask
  task mode(input logic s, input logic [2:0] a, input logic [1:0] g,
            input logic se);
    apb(1, OFS_MODE, 32'(s) << MR_SLOW_BIT | 32'(se) << MR_DQS_BIT |
        32'(g) << MR_GR_LSB | 32'h40 | 32'(a));
    {slow, al, grade, tdal} <= {s, a, g, 8'h04 + nrp};
  endtask
  // cycles of rounding, worked out here
  function automatic logic [7:0] ru(input logic [15:0] p, input logic [15:0] c);
    return 8'((32'(p) + 32'(c) - 1) / 32'(c));
  endfunction
  task wr_cfg(input logic [15:0] p, input logic [15:0] c);
    apb(1, OFS_CFG, {c, p});
    nrp = ru(p, c);
    for (i = 0; i < 100; i++) begin
      apb(0, OFS_STAT, 0);
      if (r[ST_BUSY] === 1'b0) break;
    end
    chk(r[ST_BUSY], 1'b0);
  endtask
  task pulse_chg(input logic cap);
    @(posedge mclk);
    if (cap) cap_i <= 1'b1;
    else chg_i <= 1'b1;
    tick(3);
    {cap_i, chg_i} <= 2'b00;
  endtask
  initial begin
    #2000000;
    fail_count++;
    end_of_test;
  end
  initial begin
    {mclk, rst, psel, penable, pwrite, paddr, pwdata} = {2'b01, 43'h0};
    {req, rcmd, early, cke_i, odt_i, chg_i, cap_i} = 9'h008;
    {slow, al, grade, tdal, nrp} = {6'h0, 8'h09, 8'h05};
    seed = 30116;
    tick(6);
    rst <= 1'b0;
    apb(0, OFS_MODE, 0);
    chk(r, MODE_RST);
    apb(0, OFS_CFG, 0);
    chk(r, CFG_RST);
    apb(1, OFS_STAT, 32'hffffffff);
    apb(0, OFS_STAT, 0);
    chk(r, 32'h0005_0520);
    apb(0, 8'h10, 0);
    chk({r[30:0], lerr}, 32'h1);
    $display("test registers done");
    mode(0, 0, GR_667, 1);
    tick(3);
    chk(dqs_diff, 0);
    mode(0, 0, GR_667, 0);
    tick(3);
    chk(dqs_diff, 1);
    $display("test strobe done");
    for (int k = 0; k < 6; k++) begin
      trp = (k == 0) ? 16'd11250 : 16'(1 + ($random(seed) & 32'h3fff));
      tck = (k == 0) ? 16'd1875 : 16'(500 + ($random(seed) & 32'h0fff));
      wr_cfg(trp, tck);
      chk(r[15:8], nrp);
      chk(r[23:16], 8'h04 + nrp);
    end
    wr_cfg(16'd15000, 16'd3000);
    mode(0, 0, GR_667, 0);
    $display("test rounding done");
    @(posedge mclk);
    odt_i <= 1'b1;
    tick(4);
    #1 chk(odt_term, 0);
    tick(1);
    odt_i <= 1'b0;
    #1 chk(odt_term, 1);
    tick(5);
    #1 chk(odt_term, 1);
    tick(1);
    #1 chk(odt_term, 0);
    $display("test termination done");
    for (int g = 0; g < 3; g++) begin
      mode(0, 0, 2'(g), 0);
      issue(CMD_PRE, 0, 1);
      pd_enter;
      chk(freq_ok, 1);
      pulse_chg(0);
      issue(CMD_ACT, 0, 1);
      errchk(5'h00);
      issue(CMD_PRE, 0, 1);
      pd_enter;
      issue(CMD_ACT, 1, 1);
      errchk(5'h01);
    end
    $display("test exit spacing done");
    for (int s = 0; s < 2; s++) begin
      mode(1'(s), 3'($random(seed) & 3), 2'($random(seed) & 1), 0);
      pd_enter;
      chk(freq_ok, 0);
      pulse_chg(0);
      errchk(5'h08);
      issue(CMD_RD, 0, 1);
      errchk(5'h00);
      pd_enter;
      issue(CMD_RD, 1, 1);
      errchk(5'h02);
    end
    $display("test read exit done");
    issue(CMD_WRA, 0, 1);
    issue(CMD_ACT, 0, 1);
    errchk(5'h00);
    issue(CMD_WRA, 0, 1);
    issue(CMD_ACT, 1, 1);
    errchk(5'h04);
    $display("test write ap done");
    // self refresh: command and cke fall land on the same edge
    @(posedge mclk);
    {req, rcmd, early} <= {1'b1, CMD_SREF, 1'b1};
    @(posedge mclk);
    {req, cke_i} <= 2'b00;
    tick(8);
    chk(freq_ok, 1);
    pulse_chg(0);
    issue(CMD_NOP, 0, 1);
    errchk(5'h00);
    chk(freq_ok, 0);
    $display("test self refresh done");
    pulse_chg(1);
    issue(CMD_RD, 0, 1);
    errchk(5'h10);
    pulse_chg(1);
    issue(CMD_WR, 0, 1);
    issue(CMD_RD, 0, 1);
    errchk(5'h00);
    $display("test capture done");
    end_of_test;
  end
endmodule  // tb_top
